// ===== mrs_slave.sv
// Serial-link slave: query decode, coil and holding register access
//
// Function
// R1 - Read-coils query: address, 01, start, count, CRC
// R2 - Coil reply: address, function, count, data, CRC
// R3 - Zero or over 32 coils gives exception 03
// R4 - First coil in LSB of first byte
// R5 - Coils beyond range read as zero
// R6 - Master never broadcasts read queries
// R7 - Register read query: address, 03, start, count
// R8 - Register reply: twice count, high byte first
// R9 - Failed reads answer with exception frame
// R10 - Coil write value FF00 on, 0000 off
// R11 - Broadcast coil write acts, sends nothing
// R12 - Failed coil write answers with exception
// R13 - Register write query stores value in register
// R14 - Coil 1 runs only with serial source
// R15 - Successful writes echo the whole query
// R16 - Exception function is query plus 80h
// R17 - CRC-16 on every frame, bad ones dropped
// R18 - Foreign address queries get no reply
// R19 - Other coil values give exception 03
`timescale 1ns/10ps
module mrs_slave (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Own station address
  input wire logic [7:0] slave_addr,
  // Received byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_frame_end,
  // Response byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Drive side
  output logic run_cmd,
  output logic [31:0] coils
);

  typedef struct packed {
    mrs_pkg::mrs_state_t st;
    logic [3:0] rx_cnt;
    logic [7:0][7:0] rxb;
    logic [mrs_pkg::TXB_DEPTH-1:0][7:0] txb;
    logic [3:0] tx_len;
    logic [3:0] tx_idx;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic [mrs_pkg::NUM_COILS-1:0] coils;
    logic [mrs_pkg::NUM_HOLD-1:0][15:0] hold;
    logic run;
  } mrs_slave_st_t;

  mrs_slave_st_t q;
  mrs_slave_st_t d;

  mrs_crc_if crc_bus ();

  // Shared CRC engine, used for receive check and transmit generation
  mrs_crc u_crc (
    .clock (clock),
    .rst (rst),
    .bus (crc_bus)
  );

  // Coil state by coil number, zero outside the defined range
  function automatic logic coil_bit(input logic [31:0] c,
                                    input logic [15:0] num);
    logic r;
    r = 1'b0;
    if (num != 16'h0000 && num <= mrs_pkg::MAX_COILS) begin
      r = c[5'(num - 16'h0001)];
    end
    return r;
  endfunction

  // Decode scratch
  logic [7:0] q_addr;
  logic [7:0] q_fn;
  logic [15:0] q_a;
  logic [15:0] q_v;
  logic bcast;
  logic [7:0] ex;
  logic [31:0] cw;
  logic [7:0] nb;
  logic [16:0] a_end;

  // Field view of the stored query
  always_comb begin
    q_addr = q.rxb[0];
    q_fn = q.rxb[1];
    q_a = {q.rxb[2], q.rxb[3]}; // [R1] [R7]
    q_v = {q.rxb[4], q.rxb[5]};
    bcast = (q_addr == mrs_pkg::BCAST_ADDR);
    a_end = {1'b0, q_a} + {1'b0, q_v};
  end

  // Next-state logic
  always_comb begin
    d = q;
    ex = mrs_pkg::EXC_NONE;
    cw = 32'h0000_0000;
    nb = 8'h00;
    crc_bus.clr = 1'b0;
    crc_bus.en = 1'b0;
    crc_bus.din = 8'h00;
    case (q.st)
      mrs_pkg::S_RX: begin
        // Collect bytes and run the CRC over all of them
        if (rx_valid) begin
          crc_bus.en = 1'b1;
          crc_bus.din = rx_data;
          if (q.rx_cnt < mrs_pkg::QUERY_LEN) begin
            d.rxb[q.rx_cnt[2:0]] = rx_data;
          end
          if (q.rx_cnt <= mrs_pkg::QUERY_LEN) begin
            d.rx_cnt = q.rx_cnt + 4'h1;
          end
        end
        // Whole frame seen: residue zero means CRC good
        if (rx_frame_end) begin
          crc_bus.clr = 1'b1;
          d.rx_cnt = 4'h0;
          if (q.rx_cnt == mrs_pkg::QUERY_LEN &&
              crc_bus.crc == 16'h0000) begin // [R17]
            d.st = mrs_pkg::S_EXEC;
          end
        end
      end
      mrs_pkg::S_EXEC: begin
        crc_bus.clr = 1'b1;
        d.st = mrs_pkg::S_RX;
        d.txb = '0;
        d.txb[0] = q_addr;
        d.txb[1] = q_fn;
        if (q_addr == slave_addr || bcast) begin // [R18]
          case (q_fn)
            mrs_pkg::FN_RD_COILS: begin
              if (q_v == 16'h0000 || q_v > mrs_pkg::MAX_COILS) begin
                ex = mrs_pkg::EXC_DATA; // [R3]
              end else begin
                // Pack coils from the LSB of the first byte upward
                for (int i = 0; i < mrs_pkg::NUM_COILS; i++) begin
                  if (16'(i) < q_v) begin
                    cw[i] = coil_bit(q.coils, q_a + 16'(i)); // [R4] [R5]
                  end
                end
                nb = 8'((q_v + 16'h0007) >> 3);
                d.txb[2] = nb; // [R2]
                for (int i = 0; i < 4; i++) begin
                  d.txb[3 + i] = cw[8 * i +: 8];
                end
                d.tx_len = mrs_pkg::HDR_LEN + nb[3:0];
              end
            end
            mrs_pkg::FN_RD_HOLD: begin
              if (q_v == 16'h0000 || q_v > mrs_pkg::MAX_REGS) begin
                ex = mrs_pkg::EXC_DATA; // [R9]
              end else if (a_end > mrs_pkg::HOLD_LIMIT) begin
                ex = mrs_pkg::EXC_ADDR; // [R9]
              end else begin
                d.txb[2] = 8'(q_v << 1); // [R8]
                for (int j = 0; j < 4; j++) begin
                  if (16'(j) < q_v) begin
                    d.txb[3 + 2 * j] = q.hold[5'(q_a + 16'(j))][15:8];
                    d.txb[4 + 2 * j] = q.hold[5'(q_a + 16'(j))][7:0];
                  end
                end
                d.tx_len = mrs_pkg::HDR_LEN + 4'(q_v << 1);
              end
            end
            mrs_pkg::FN_WR_COIL: begin
              if (q_v != mrs_pkg::COIL_ON_VAL &&
                  q_v != mrs_pkg::COIL_OFF_VAL) begin
                ex = mrs_pkg::EXC_DATA; // [R19] [R12]
              end else if (q_a == 16'h0000 ||
                           q_a > mrs_pkg::MAX_COILS) begin
                ex = mrs_pkg::EXC_ADDR; // [R12]
              end else begin
                // Broadcast writes act here too
                d.coils[5'(q_a - 16'h0001)] =
                  (q_v == mrs_pkg::COIL_ON_VAL); // [R10] [R11]
                d.txb[5:0] = q.rxb[5:0]; // [R15]
                d.tx_len = mrs_pkg::ECHO_LEN;
              end
            end
            mrs_pkg::FN_WR_HOLD: begin
              if (q_a >= 16'(mrs_pkg::NUM_HOLD)) begin
                ex = mrs_pkg::EXC_ADDR;
              end else begin
                d.hold[q_a[4:0]] = q_v; // [R13]
                d.txb[5:0] = q.rxb[5:0]; // [R15]
                d.tx_len = mrs_pkg::ECHO_LEN;
              end
            end
            default: begin
              ex = mrs_pkg::EXC_FUNC;
            end
          endcase
          // Exception frame replaces the data reply
          if (ex != mrs_pkg::EXC_NONE) begin
            d.txb[1] = q_fn | mrs_pkg::EXC_FLAG; // [R16]
            d.txb[2] = ex;
            d.tx_len = mrs_pkg::EXC_LEN;
          end
          // Broadcast queries never answer
          if (!bcast) begin // [R11]
            d.st = mrs_pkg::S_TXD;
            d.tx_idx = 4'h0;
            d.tx_valid = 1'b1;
            d.tx_data = d.txb[0];
          end
        end
      end
      mrs_pkg::S_TXD: begin
        // Send body bytes, folding each into the CRC
        if (tx_ready) begin
          crc_bus.en = 1'b1;
          crc_bus.din = q.tx_data; // [R17]
          d.tx_idx = q.tx_idx + 4'h1;
          if (q.tx_idx + 4'h1 == q.tx_len) begin
            d.tx_valid = 1'b0;
            d.st = mrs_pkg::S_TXW;
          end else begin
            d.tx_data = q.txb[q.tx_idx + 4'h1];
          end
        end
      end
      mrs_pkg::S_TXW: begin
        // CRC settled, present its low byte first
        d.tx_valid = 1'b1;
        d.tx_data = crc_bus.crc[7:0];
        d.tx_idx = 4'h0;
        d.st = mrs_pkg::S_TXC;
      end
      mrs_pkg::S_TXC: begin
        if (tx_ready) begin
          if (q.tx_idx == 4'h0) begin
            d.tx_data = crc_bus.crc[15:8];
            d.tx_idx = 4'h1;
            d.tx_last = 1'b1;
          end else begin
            // Reply sum must not leak into the next query's check
            crc_bus.clr = 1'b1; // [R17]
            d.tx_valid = 1'b0;
            d.tx_last = 1'b0;
            d.st = mrs_pkg::S_RX;
          end
        end
      end
      default: begin
        d.st = mrs_pkg::S_RX;
      end
    endcase
    // Run follows coil 1 only with the serial source selected
    d.run = coil_bit(d.coils, mrs_pkg::RUN_COIL) &&
            (d.hold[mrs_pkg::RUNSRC_REG] ==
             mrs_pkg::RUNSRC_SERIAL); // [R14]
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.st <= mrs_pkg::S_RX;
    end else begin
      q <= d;
    end
  end

  // Registered outputs
  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign tx_last = q.tx_last;
  assign run_cmd = q.run;
  assign coils = q.coils;

endmodule

// ===== mrs_pkg.sv
// Constants, state codes and CRC step shared by the coil/register slave
package mrs_pkg;

  // Function codes and exception encoding
  localparam logic [7:0] FN_RD_COILS = 8'h01;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_WR_COIL = 8'h05;
  localparam logic [7:0] FN_WR_HOLD = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;

  // Addresses and change values
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] COIL_ON_VAL = 16'hFF00;
  localparam logic [15:0] COIL_OFF_VAL = 16'h0000;

  // Frame layout
  localparam logic [3:0] QUERY_LEN = 4'h8;
  localparam logic [3:0] ECHO_LEN = 4'h6;
  localparam logic [3:0] EXC_LEN = 4'h3;
  localparam logic [3:0] HDR_LEN = 4'h3;
  localparam int TXB_DEPTH = 11;

  // Data space sizes
  localparam int NUM_COILS = 32;
  localparam logic [15:0] MAX_COILS = 16'h0020;
  localparam logic [15:0] MAX_REGS = 16'h0004;
  localparam int NUM_HOLD = 32;
  localparam logic [16:0] HOLD_LIMIT = 17'h00020;

  // Run command coil and its source setting
  localparam logic [15:0] RUN_COIL = 16'h0001;
  localparam logic [4:0] RUNSRC_REG = 5'h01;
  localparam logic [15:0] RUNSRC_SERIAL = 16'h0003;

  // CRC-16 parameters, reflected form
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // One-hot controller states
  typedef enum logic [4:0] {
    S_RX = 5'b00001,
    S_EXEC = 5'b00010,
    S_TXD = 5'b00100,
    S_TXW = 5'b01000,
    S_TXC = 5'b10000
  } mrs_state_t;

  // Advance the CRC by one byte, low bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ===== mrs_crc_if.sv
// Carrier between the slave controller and its CRC engine
`timescale 1ns/10ps
interface mrs_crc_if;
  logic clr;
  logic en;
  logic [7:0] din;
  logic [15:0] crc;

  modport eng (input clr, input en, input din, output crc);
  modport user (output clr, output en, output din, input crc);
endinterface

// ===== mrs_crc.sv
// Byte-wide CRC-16 accumulator
`timescale 1ns/10ps
module mrs_crc (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Controller side
  mrs_crc_if.eng bus
);

  typedef struct packed {
    logic [15:0] crc;
  } mrs_crc_st_t;

  mrs_crc_st_t q;
  mrs_crc_st_t d;

  // Clear wins over a byte in the same cycle
  always_comb begin
    d = q;
    if (bus.clr) begin
      d.crc = mrs_pkg::CRC_INIT;
    end else if (bus.en) begin
      d.crc = mrs_pkg::crc_step(q.crc, bus.din); // [R17]
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      q.crc <= mrs_pkg::CRC_INIT;
    end else begin
      q <= d;
    end
  end

  assign bus.crc = q.crc;

endmodule

// ===== mrs_slave_properties.sv
// Assertions on the slave's reply stream and drive outputs
`timescale 1ns/10ps
module mrs_slave_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire logic [7:0] slave_addr,
  input wire logic rx_frame_end,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic run_cmd,
  input wire logic [31:0] coils
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Offered byte holds until taken
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply byte changed before taken");
  // Last flag only with an offered byte
  property p_last;
    tx_last |-> tx_valid;
  endproperty
  a_last: assert property (p_last)
    else $error("last flag without valid");
  // Reply ends after the second CRC byte
  property p_end;
    tx_valid && tx_ready && tx_last |=> !tx_valid && !tx_last;
  endproperty
  a_end: assert property (p_end)
    else $error("reply went on after last byte");
  // Body byte taken, next byte within two cycles
  property p_gap;
    tx_valid && tx_ready && !tx_last |-> ##[1:2] tx_valid;
  endproperty
  a_gap: assert property (p_gap)
    else $error("reply stalled mid frame");
  // First reply byte is the own address
  property p_addr;
    $past(rx_frame_end, 2) && tx_valid |-> tx_data == slave_addr;
  endproperty
  a_addr: assert property (p_addr)
    else $error("reply address wrong");
  // A reply starts only two cycles after a frame end
  property p_start;
    $rose(tx_valid) && !$past(tx_valid, 2) |-> $past(rx_frame_end, 2);
  endproperty
  a_start: assert property (p_start)
    else $error("reply without a query");
  // Run command needs coil 1 on
  property p_run;
    run_cmd |-> coils[0];
  endproperty
  a_run: assert property (p_run)
    else $error("run without coil 1");
  // Coils change only in the decode cycle
  property p_coil_when;
    !$stable(coils) |-> $past(rx_frame_end, 2);
  endproperty
  a_coil_when: assert property (p_coil_when)
    else $error("coils changed outside decode");
  // Run command changes only in the decode cycle
  property p_run_when;
    !$stable(run_cmd) |-> $past(rx_frame_end, 2);
  endproperty
  a_run_when: assert property (p_run_when)
    else $error("run changed outside decode");
endmodule

// ===== mrs_master_model.sv
// Serial master model: sends framed queries, gathers replies
`timescale 1ns/10ps
module mrs_master_model (
  // Clock
  input wire logic clock,
  // Query stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_end,
  // Reply stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] rsp[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
  end
  // Reflected CRC-16 over one byte
  function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  // One query out, reply gathered with random stalls
  task automatic xfer(input logic [47:0] b, input logic bad);
    logic [15:0] c;
    logic [7:0] d;
    logic take;
    logic fin;
    c = 16'hFFFF;
    for (int i = 0; i < 6; i++) c = crc_byte(c, b[47-8*i -: 8]);
    if (bad) c = ~c;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      rx_valid = 1'b1;
      rx_data = i < 6 ? b[47-8*i -: 8] : (i == 6 ? c[7:0] : c[15:8]);
    end
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_frame_end = 1'b1;
    @(posedge clock);
    #1;
    rx_frame_end = 1'b0;
    rsp.delete();
    for (int n = 0; n < 40; n++) begin
      tx_ready = ($urandom % 4) != 0;
      take = tx_valid && tx_ready;
      fin = take && tx_last;
      d = tx_data;
      @(posedge clock);
      #1;
      if (take) rsp.push_back(d);
      if (fin) break;
    end
  endtask
endmodule

// ===== tb_mrs_slave.sv
// Self-checking bench for the coil and register slave
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_mrs_slave;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] slave_addr = 8'h08;
  logic rx_valid, rx_frame_end, tx_valid, tx_last, tx_ready, run_cmd;
  logic [7:0] rx_data, tx_data, f;
  logic [31:0] coils;
  logic [31:0] exp_coils = 32'h0;
  logic [15:0] regs [32];
  logic [15:0] a, v;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // Clock and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  mrs_slave DUT (.clock, .rst, .slave_addr, .rx_valid, .rx_data,
    .rx_frame_end, .tx_valid, .tx_data, .tx_last, .tx_ready, .run_cmd, .coils);
  mrs_master_model master (.clock, .rx_valid, .rx_data, .rx_frame_end,
    .tx_valid, .tx_data, .tx_last, .tx_ready);
  // Verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Send one query, predict and compare the reply
  task automatic run(input logic [7:0] ad, fn, input logic [15:0] a, v,
                     input logic bad = 1'b0);
    logic [7:0] e[$];
    logic [7:0] x, b;
    logic [15:0] c;
    logic act;
    int p;
    x = 8'h00;
    act = !bad && (ad == slave_addr || ad == 8'h00);
    master.xfer({ad, fn, a, v}, bad);
    e = {slave_addr, fn};
    if (fn == 8'h01) begin
      if (v == 0 || v > 32) x = 8'h03;
      else e.push_back(8'((v + 7) / 8));
      for (int k = 0; x == 0 && k < (v + 7) / 8; k++) begin
        b = 8'h00;
        for (int j = 0; j < 8; j++) begin
          p = a + 8 * k + j;
          if (8 * k + j < v && p >= 1 && p <= 32) b[j] = exp_coils[p-1];
        end
        e.push_back(b);
      end
    end else if (fn == 8'h03) begin
      if (v == 0 || v > 4) x = 8'h03;
      else if (a + v > 32) x = 8'h02;
      else e.push_back(8'(2 * v));
      for (int k = 0; x == 0 && k < v; k++) e = {e, regs[a+k][15:8], regs[a+k][7:0]};
    end else if (fn == 8'h05) begin
      if (v != 16'hFF00 && v != 16'h0000) x = 8'h03;
      else if (a == 0 || a > 32) x = 8'h02;
      else if (act) exp_coils[a-1] = v[15];
    end else if (fn == 8'h06) begin
      if (a > 31) x = 8'h02;
      else if (act) regs[a] = v;
    end else x = 8'h01;
    if (fn == 8'h05 || fn == 8'h06) e = {e, a[15:8], a[7:0], v[15:8], v[7:0]};
    if (x != 0) e = {slave_addr, fn | 8'h80, x};
    if (!act || ad == 8'h00) e = {};
    if (e.size() > 0) begin
      c = 16'hFFFF;
      foreach (e[i]) c = master.crc_byte(c, e[i]);
      e = {e, c[7:0], c[15:8]};
    end
    `CHK(master.rsp.size(), e.size())
    foreach (e[i]) if (i < master.rsp.size()) `CHK(master.rsp[i], e[i])
    `CHK(coils, exp_coils)
    `CHK(run_cmd, exp_coils[0] && regs[1] == 16'h0003)
  endtask
  // Corner cases, a mid-run reset, then random traffic
  initial begin
    void'($urandom(32'h11b29cc8));
    foreach (regs[i]) regs[i] = 16'h0000;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    for (int i = 7; i <= 11; i++) if (i != 10) run(8'h08, 8'h05, 16'(i), 16'hFF00);
    run(8'h08, 8'h01, 16'h0007, 16'h0006);
    run(8'h08, 8'h01, 16'h0001, 16'h0000);
    run(8'h08, 8'h01, 16'h0001, 16'h0021);
    run(8'h08, 8'h01, 16'h001E, 16'h0008);
    run(8'h08, 8'h03, 16'h0000, 16'h0005);
    run(8'h08, 8'h03, 16'h001E, 16'h0003);
    run(8'h08, 8'h05, 16'h0003, 16'h1234);
    run(8'h08, 8'h05, 16'h0000, 16'hFF00);
    run(8'h08, 8'h06, 16'h0020, 16'h0001);
    run(8'h08, 8'h08, 16'h0000, 16'h0000);
    run(8'h08, 8'h06, 16'h0001, 16'h0003);
    run(8'h08, 8'h05, 16'h0001, 16'hFF00);
    run(8'h08, 8'h06, 16'h0001, 16'h0002);
    run(8'h00, 8'h05, 16'h0005, 16'hFF00);
    run(8'h09, 8'h05, 16'h0006, 16'hFF00);
    run(8'h08, 8'h05, 16'h0006, 16'hFF00, 1'b1);
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    `CHK(coils, 32'h0)
    `CHK(tx_valid, 1'b0)
    exp_coils = 32'h0;
    foreach (regs[i]) regs[i] = 16'h0000;
    repeat (150) begin
      f = ($urandom % 4) * 2 + 8'h01;
      f = f == 8'h07 ? 8'h06 : f;
      a = 16'($urandom % 36);
      v = f == 8'h05 ? {8'($urandom % 2) * 8'hFF, 8'h00} : 16'($urandom);
      if (f == 8'h01) v = 16'($urandom % 34);
      if (f == 8'h03) v = 16'($urandom % 6);
      run(f[2] && $urandom % 5 == 0 ? 8'h00 : 8'h08, f, a, v);
    end
    complete_run();
  end
endmodule
bind mrs_slave mrs_slave_chk u_chk (.clock, .rst, .slave_addr, .rx_frame_end,
  .tx_valid, .tx_data, .tx_last, .tx_ready, .run_cmd, .coils);
